// ==== design/difd_pkg.sv ====
package difd_pkg;

    localparam int NUM_IN      = 6;
    localparam int CODE_W      = 6;
    localparam int FREQ_W      = 16;
    localparam int SCAN_W      = 11;

    // function codes of the multi-function inputs
    localparam logic [5:0] FN_HOLD       = 6'h0B;
    localparam logic [5:0] FN_ALT_RUN    = 6'h0C;
    localparam logic [5:0] FN_ALT_FREQ   = 6'h0D;
    localparam logic [5:0] FN_ESTOP      = 6'h0E;
    localparam logic [5:0] FN_BASEBLOCK  = 6'h0F;
    localparam logic [5:0] FN_FAULT_RST  = 6'h11;
    localparam logic [5:0] FN_SEARCH_MAX = 6'h13;
    localparam logic [5:0] FN_EXT_FAULT  = 6'h19;
    localparam logic [5:0] FN_THREE_WIRE = 6'h1A;
    localparam logic [5:0] FN_LOCAL      = 6'h1B;
    localparam logic [5:0] FN_COMM       = 6'h1C;
    localparam logic [5:0] FN_JOG        = 6'h1D;
    localparam logic [5:0] FN_ACC2       = 6'h1E;
    localparam logic [5:0] FN_OVERHEAT   = 6'h1F;
    localparam logic [5:0] FN_SEARCH_REF = 6'h22;

    // run/frequency source selections
    localparam logic [2:0] SRC_MAIN      = 3'h0;
    localparam logic [2:0] SRC_ALT       = 3'h1;
    localparam logic [2:0] SRC_KEYPAD    = 3'h2;
    localparam logic [2:0] SRC_COMM      = 3'h3;
    localparam logic [2:0] SRC_TERMINAL  = 3'h4;

    // ramp rate selections
    localparam logic [1:0] RAMP_SET1     = 2'h0;
    localparam logic [1:0] RAMP_SET2     = 2'h1;
    localparam logic [1:0] RAMP_ESTOP    = 2'h2;

    // scan qualification time
    localparam int CLK_MHZ       = 200;
    localparam int SCAN4_MS      = 4;
    localparam int SCAN8_MS      = 8;
    localparam int SCAN_TICK_US  = 100;
    localparam int TICK_CYC      = SCAN_TICK_US * CLK_MHZ;
    localparam int SCAN4_TICKS   = SCAN4_MS * 1000 / SCAN_TICK_US;
    localparam int SCAN8_TICKS   = SCAN8_MS * 1000 / SCAN_TICK_US;

    localparam logic [FREQ_W-1:0] FREQ_RST = 16'h0000;

    typedef enum logic [3:0] {
        DIFD_IDLE  = 4'b0001,
        DIFD_RUN   = 4'b0010,
        DIFD_BLOCK = 4'b0100,
        DIFD_FAULT = 4'b1000
    } difd_state_e;

endpackage

// ==== design/difd_filter.sv ====
`timescale 1ns/1ps
module difd_filter (
    input  wire logic                          clock,     // system clock
    input  wire logic                          rstn,      // async reset
    input  wire logic                          clk_en,    // freeze when low
    input  wire logic                          tick,      // scan tick
    input  wire logic                          slow_scan, // 8 ms when high
    input  wire logic                          raw_in,    // synchronised pin
    output logic                               qual_out   // qualified level
);

    logic [difd_pkg::SCAN_W-1:0] cnt_reg;
    logic                        qual_reg;

    wire [difd_pkg::SCAN_W-1:0] limit = slow_scan ?
        difd_pkg::SCAN_W'(difd_pkg::SCAN8_TICKS) :
        difd_pkg::SCAN_W'(difd_pkg::SCAN4_TICKS);
    wire differs = raw_in != qual_reg;

    // a new level must hold for the full scan time before it is taken
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cnt_reg  <= '0;
            qual_reg <= 1'b0;
        end else if (clk_en) begin
            if (!differs) begin
                cnt_reg <= '0;
            end else if (tick) begin
                if (cnt_reg + 1'b1 >= limit) begin
                    qual_reg <= raw_in;
                    cnt_reg  <= '0;
                end else begin
                    cnt_reg <= cnt_reg + 1'b1;
                end
            end
        end
    end

    assign qual_out = qual_reg;

endmodule

// ==== design/difd_dispatch.sv ====
`timescale 1ns/1ps
// How it works
// - code 11 freezes ramping at present frequency; release resumes.
// - retention 1 with hold active stores the reference persistently.
// - retention 1, run under hold ramps toward stored reference.
// - retention 0, run under hold keeps reference and output at zero.
// - code 12 selects alternative run source; code 27 overrides it.
// - code 13 selects alternative frequency source; code 27 overrides it.
// - code 14 ramps to zero with emergency deceleration, then stops.
// - code 15 switches output off; baseblock message names the input.
// - baseblock release in run resumes via speed search or from zero.
// - baseblock applied in deceleration leaves drive stopped on release.
// - fault: output off; cleared by code 17, key or power once run drops.
// - run present at power-up starts running automatically.
// - code 25 coasts motor, shows external fault with terminal number.
// - code 27 on is local keypad, lamps off; off is remote, lamps on.
// - three-wire reserves terminals one, two; local only on three-six.
// - code 28 on takes sources from comm link; off from analog/terminals.
// - code 26 on inputs three-six makes terminal one run, two stop.
// - code 29 uses jog frequency as command.
// - code 30 uses second accel and decel times.
// - code 31 shows overheat warning, keeps running, clears on release.
// - code 19 searches from max frequency; code 34 from command.
// - an input counts only after holding for the 4 or 8 ms scan time.
module difd_dispatch (
    input  wire logic                          clock,          // 200 MHz
    input  wire logic                          rstn,           // async reset
    input  wire logic                          clk_en,         // freeze low
    input  wire logic [5:0]                    input_pins,     // raw terminals
    input  wire logic [35:0]                   func_codes,     // 6 bits each
    input  wire logic                          slow_scan,      // 8 ms scan
    input  wire logic                          retain_ref,     // retention
    input  wire logic                          search_from_ref,// resume search
    input  wire logic                          run_cmd,        // selected run
    input  wire logic                          decelerating,   // ramp falling
    input  wire logic                          fault_trip,     // fault event
    input  wire logic                          reset_key,      // keypad reset
    input  wire logic                          motor_stopped,  // ramp at zero
    input  wire logic [15:0]                   freq_ref,       // current ref
    input  wire logic [15:0]                   nv_ref,         // stored at boot
    output logic                               output_enable,  // bridge on
    output logic                               ramp_hold,      // hold ramp
    output logic [1:0]                         ramp_sel,       // rate set
    output logic                               force_zero,     // ref held 0
    output logic                               use_stored,     // use stored
    output logic [15:0]                        stored_ref,     // saved ref
    output logic                               store_strobe,   // nv write
    output logic                               use_jog,        // jog freq
    output logic [2:0]                         run_source,     // run src
    output logic [2:0]                         freq_source,    // freq src
    output logic                               run_source_lamp,// seq lamp
    output logic                               ref_lamp,       // ref lamp
    output logic                               search_max,     // search max
    output logic                               search_ref,     // search ref
    output logic                               baseblock_message,      // msg
    output logic                               external_fault_message, // msg
    output logic                               overheat_warning_message,// msg
    output logic [2:0]                         message_input,  // 1..6
    output logic                               fault_active,   // latched
    output logic                               three_wire,     // 3-wire mode
    output logic                               first_input_terminal,  // run
    output logic                               second_input_terminal, // stop
    output logic                               drive_running   // state run
);

    ////////////////////////////////////////////////////////////////////////
    // synchronisers, scan tick and per-input qualification

    logic [5:0]  sync1_reg;
    logic [5:0]  sync2_reg;
    logic [15:0] tick_cnt_reg;
    logic        tick_reg;
    logic [5:0]  qual;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else if (clk_en) begin
            sync1_reg <= input_pins;
            sync2_reg <= sync1_reg;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            tick_cnt_reg <= '0;
            tick_reg     <= 1'b0;
        end else if (clk_en) begin
            tick_reg <= tick_cnt_reg == 16'(difd_pkg::TICK_CYC - 1);
            if (tick_cnt_reg == 16'(difd_pkg::TICK_CYC - 1)) begin
                tick_cnt_reg <= '0;
            end else begin
                tick_cnt_reg <= tick_cnt_reg + 16'h0001;
            end
        end
    end

    // per-input function decode; local on slots one and two also depends on three-wire in slots three to six
    logic [5:0] hit_hold, hit_altr, hit_altf, hit_estop, hit_bb, hit_rst;
    logic [5:0] hit_smax, hit_ef, hit_3w, hit_loc, hit_com, hit_jog;
    logic [5:0] hit_acc2, hit_oh, hit_sref, hit_any_bb, hit_any_ef;
    logic [5:0] code_3w;

    wire three_wire_w = |code_3w;

    genvar gi;
    generate
        for (gi = 0; gi < difd_pkg::NUM_IN; gi++) begin : g_in
            wire [5:0] code = func_codes[gi*6 +: 6];
            difd_filter u_filt (
                .clock     (clock),
                .rstn      (rstn),
                .clk_en    (clk_en),
                .tick      (tick_reg),
                .slow_scan (slow_scan),
                .raw_in    (sync2_reg[gi]),
                .qual_out  (qual[gi])
            );
            // unknown codes match nothing and so have no effect
            assign code_3w[gi]   = (gi >= 2)
                                   && code == difd_pkg::FN_THREE_WIRE;
            assign hit_3w[gi]    = code_3w[gi];
            assign hit_hold[gi]  = qual[gi] && code == difd_pkg::FN_HOLD;
            assign hit_altr[gi]  = qual[gi] && code == difd_pkg::FN_ALT_RUN;
            assign hit_altf[gi]  = qual[gi] && code == difd_pkg::FN_ALT_FREQ;
            assign hit_estop[gi] = qual[gi] && code == difd_pkg::FN_ESTOP;
            assign hit_bb[gi]    = qual[gi] && code == difd_pkg::FN_BASEBLOCK;
            assign hit_rst[gi]   = qual[gi] && code == difd_pkg::FN_FAULT_RST;
            assign hit_smax[gi]  = qual[gi] && code == difd_pkg::FN_SEARCH_MAX;
            assign hit_ef[gi]    = qual[gi] && code == difd_pkg::FN_EXT_FAULT;
            // local/remote on terminals one and two is void in three-wire
            assign hit_loc[gi]   = qual[gi] && code == difd_pkg::FN_LOCAL
                                   && !(three_wire_w && gi < 2);
            assign hit_com[gi]   = qual[gi] && code == difd_pkg::FN_COMM;
            assign hit_jog[gi]   = qual[gi] && code == difd_pkg::FN_JOG;
            assign hit_acc2[gi]  = qual[gi] && code == difd_pkg::FN_ACC2;
            assign hit_oh[gi]    = qual[gi] && code == difd_pkg::FN_OVERHEAT;
            assign hit_sref[gi]  = qual[gi] && code == difd_pkg::FN_SEARCH_REF;
            assign hit_any_bb[gi] = hit_bb[gi];
            assign hit_any_ef[gi] = hit_ef[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // combined decode

    wire hold_w  = |hit_hold;
    wire estop_w = |hit_estop;
    wire bb_w    = |hit_bb;
    wire ef_w    = |hit_ef;
    wire loc_w   = |hit_loc;
    wire com_w   = |hit_com;
    wire oh_w    = |hit_oh;

    function automatic logic [2:0] first_hit(input logic [5:0] v);
        logic [2:0] n;
        n = 3'h0;
        for (int i = 5; i >= 0; i--) begin
            if (v[i]) begin
                n = 3'(i + 1);
            end
        end
        return n;
    endfunction

    wire [2:0] bb_num = first_hit(hit_any_bb);
    wire [2:0] ef_num = first_hit(hit_any_ef);

    // local beats comm/alt; comm beats alt switching
    wire [2:0] run_src_w = loc_w ? difd_pkg::SRC_KEYPAD :
        com_w ? difd_pkg::SRC_COMM :
        (|hit_altr) ? difd_pkg::SRC_ALT : difd_pkg::SRC_MAIN;
    wire [2:0] frq_src_w = loc_w ? difd_pkg::SRC_KEYPAD :
        com_w ? difd_pkg::SRC_COMM :
        (|hit_altf) ? difd_pkg::SRC_ALT :
        difd_pkg::SRC_TERMINAL;

    wire [1:0] ramp_w = estop_w ? difd_pkg::RAMP_ESTOP :
        (|hit_acc2) ? difd_pkg::RAMP_SET2 : difd_pkg::RAMP_SET1;

    ////////////////////////////////////////////////////////////////////////
    // run state

    difd_pkg::difd_state_e state_reg, state_next;
    logic bb_in_decel_reg;
    logic estop_latch_reg;
    logic resume_search_reg;

    wire fault_clear = (|hit_rst || reset_key) && !run_cmd;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            difd_pkg::DIFD_IDLE: begin
                // a run level already present after reset starts the drive
                if (run_cmd && !estop_latch_reg) begin
                    state_next = difd_pkg::DIFD_RUN;
                end
            end
            difd_pkg::DIFD_RUN: begin
                if (!run_cmd || (estop_latch_reg && motor_stopped)) begin
                    state_next = difd_pkg::DIFD_IDLE;
                end
            end
            difd_pkg::DIFD_BLOCK: begin
                if (!bb_w) begin
                    state_next = (bb_in_decel_reg || !run_cmd) ?
                    difd_pkg::DIFD_IDLE : difd_pkg::DIFD_RUN;
                end
            end
            difd_pkg::DIFD_FAULT: begin
                if (fault_clear && !ef_w) begin
                    state_next = difd_pkg::DIFD_IDLE;
                end
            end
            default: state_next = difd_pkg::DIFD_IDLE;
        endcase
        if (fault_trip || ef_w) begin
            state_next = difd_pkg::DIFD_FAULT;
        end else if (bb_w && state_reg != difd_pkg::DIFD_FAULT) begin
            state_next = difd_pkg::DIFD_BLOCK;
        end
    end

    wire bb_entry = state_next == difd_pkg::DIFD_BLOCK
                    && state_reg != difd_pkg::DIFD_BLOCK;
    wire bb_leave_run = state_reg == difd_pkg::DIFD_BLOCK
                        && state_next == difd_pkg::DIFD_RUN;
    wire bb_leave_stop = state_reg == difd_pkg::DIFD_BLOCK
                         && state_next == difd_pkg::DIFD_IDLE;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_reg         <= difd_pkg::DIFD_IDLE;
            bb_in_decel_reg   <= 1'b0;
            estop_latch_reg   <= 1'b0;
            resume_search_reg <= 1'b0;
        end else if (clk_en) begin
            state_reg <= state_next;
            if (bb_entry) begin
                bb_in_decel_reg <= decelerating
                                   && state_reg == difd_pkg::DIFD_RUN;
            end
            // a stop after baseblock also waits for the run level to drop
            if (estop_w || bb_leave_stop) begin
                estop_latch_reg <= 1'b1;
            end else if (!run_cmd) begin
                estop_latch_reg <= 1'b0;
            end
            resume_search_reg <= bb_leave_run
                                 && search_from_ref;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reference retention

    logic [15:0] stored_reg;
    logic        hold_d_reg;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            stored_reg   <= difd_pkg::FREQ_RST;
            hold_d_reg   <= 1'b0;
            store_strobe <= 1'b0;
        end else if (clk_en) begin
            hold_d_reg   <= hold_w;
            store_strobe <= 1'b0;
            if (retain_ref && hold_w && !hold_d_reg) begin
                stored_reg   <= freq_ref;
                store_strobe <= 1'b1;
            end else if (state_reg == difd_pkg::DIFD_IDLE && !hold_w) begin
                stored_reg <= nv_ref;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered outputs

    wire running_w = state_next == difd_pkg::DIFD_RUN;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            output_enable            <= 1'b0;
            ramp_hold                <= 1'b0;
            ramp_sel                 <= difd_pkg::RAMP_SET1;
            force_zero               <= 1'b0;
            use_stored               <= 1'b0;
            stored_ref               <= difd_pkg::FREQ_RST;
            use_jog                  <= 1'b0;
            run_source               <= difd_pkg::SRC_MAIN;
            freq_source              <= difd_pkg::SRC_TERMINAL;
            run_source_lamp          <= 1'b1;
            ref_lamp                 <= 1'b1;
            search_max               <= 1'b0;
            search_ref               <= 1'b0;
            baseblock_message        <= 1'b0;
            external_fault_message   <= 1'b0;
            overheat_warning_message <= 1'b0;
            message_input            <= 3'h0;
            fault_active             <= 1'b0;
            three_wire               <= 1'b0;
            first_input_terminal     <= 1'b0;
            second_input_terminal    <= 1'b0;
            drive_running            <= 1'b0;
        end else if (clk_en) begin
            output_enable <= running_w;
            ramp_hold     <= hold_w && !estop_w;
            ramp_sel      <= ramp_w;
            force_zero    <= hold_w && !retain_ref;
            use_stored    <= hold_w && retain_ref;
            stored_ref    <= stored_reg;
            use_jog       <= |hit_jog;
            run_source    <= run_src_w;
            freq_source   <= frq_src_w;
            run_source_lamp <= !loc_w;
            ref_lamp        <= !loc_w;
            search_max    <= |hit_smax;
            search_ref    <= (|hit_sref) || resume_search_reg;
            baseblock_message      <= state_next == difd_pkg::DIFD_BLOCK;
            external_fault_message <= ef_w;
            overheat_warning_message <= oh_w;
            message_input <= ef_w ? ef_num : (bb_w ? bb_num : 3'h0);
            fault_active  <= state_next == difd_pkg::DIFD_FAULT;
            three_wire    <= three_wire_w;
            first_input_terminal  <= three_wire_w && qual[0];
            second_input_terminal <= three_wire_w && qual[1];
            drive_running <= running_w;
        end
    end

endmodule

// ==== test/difd_switches.sv ====
`timescale 1ns/1ps
module difd_switches (
    input  wire logic       clock, // bench clock
    input  wire logic       rstn,  // async reset
    input  wire logic [5:0] press, // contact positions wanted
    output logic      [5:0] pins   // terminal levels seen by the drive
);
    logic [5:0] last_reg;
    logic [3:0] bounce_reg;
    // contacts chatter briefly, then hold their level steadily
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            last_reg   <= 6'h00;
            bounce_reg <= 4'h0;
            pins       <= 6'h00;
        end else begin
            last_reg <= press;
            if (press != last_reg) bounce_reg <= 4'hF;
            else if (bounce_reg != 4'h0) bounce_reg <= bounce_reg - 4'h1;
            pins <= (bounce_reg[0] && bounce_reg != 4'h0) ? ~press : press;
        end
    end
endmodule

// ==== test/difd_dispatch_chk.sv ====
`timescale 1ns/1ps
module difd_dispatch_chk (
    input wire logic       clock,                  // system clock
    input wire logic       rstn,                   // async reset
    input wire logic       run_cmd,                // run present
    input wire logic       fault_trip,             // fault event
    input wire logic       output_enable,          // bridge on
    input wire logic       fault_active,           // fault state
    input wire logic       baseblock_message,      // block shown
    input wire logic       store_strobe,           // nv write
    input wire logic       external_fault_message, // fault shown
    input wire logic       run_source_lamp,        // run lamp
    input wire logic       ref_lamp,               // ref lamp
    input wire logic       force_zero,             // zero hold
    input wire logic       use_stored,             // stored ref
    input wire logic [2:0] message_input,          // input number
    input wire logic [2:0] run_source              // run source
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    chk_fault_out_off: assert property (
        fault_active |-> !output_enable)
        else $error("output on during fault");
    chk_trip_sets_fault: assert property (
        $rose(fault_trip) |-> ##[1:4] fault_active)
        else $error("trip did not latch fault");
    chk_fault_needs_stop: assert property (
        fault_active && run_cmd && $past(run_cmd) |=> fault_active)
        else $error("fault cleared with run present");
    chk_block_out_off: assert property (
        baseblock_message |-> !output_enable)
        else $error("output on during baseblock");
    chk_msg_input_range: assert property (
        (baseblock_message || external_fault_message)
        |-> message_input inside {[3'h1:3'h6]})
        else $error("message input number out of range");
    chk_ext_fault_off: assert property (
        external_fault_message |-> !output_enable)
        else $error("output on during external fault");
    chk_local_lamps_off: assert property (
        run_source == difd_pkg::SRC_KEYPAD |-> !run_source_lamp && !ref_lamp)
        else $error("lamps lit in local mode");
    chk_strobe_one_cycle: assert property (
        store_strobe |=> !store_strobe)
        else $error("store strobe longer than one cycle");
    chk_zero_not_stored: assert property (
        force_zero |-> !use_stored)
        else $error("zero hold and stored reference together");
endmodule
bind difd_dispatch difd_dispatch_chk u_chk (.clock, .rstn, .run_cmd,
    .fault_trip, .output_enable, .fault_active, .baseblock_message,
    .store_strobe, .external_fault_message, .run_source_lamp, .ref_lamp,
    .force_zero, .use_stored, .message_input, .run_source);

// ==== test/difd_dispatch_tb.sv ====
`timescale 1ns/1ps
module difd_dispatch_tb;
    logic clock = 0, rstn = 0, clk_en = 1, slow_scan = 0, retain_ref = 1;
    logic search_from_ref = 1, run_cmd = 1, decelerating = 0, fault_trip = 0;
    logic reset_key = 0, motor_stopped = 0;
    logic [15:0] freq_ref = 16'h1234, nv_ref = 16'h0ABC, stored_ref;
    logic [5:0]  press = 6'h00, input_pins;
    logic [35:0] func_codes = {30'h0, difd_pkg::FN_OVERHEAT};
    logic output_enable, ramp_hold, force_zero, use_stored, store_strobe;
    logic use_jog, run_source_lamp, ref_lamp, search_max, search_ref;
    logic baseblock_message, external_fault_message, overheat_warning_message;
    logic fault_active, three_wire, first_input_terminal;
    logic second_input_terminal, drive_running;
    logic [1:0] ramp_sel;
    logic [2:0] run_source, freq_source, message_input;
    int failures = 0, n_checks = 0, i;
    difd_switches sw (.clock, .rstn, .press, .pins(input_pins));
    difd_dispatch dut (.clock, .rstn, .clk_en, .input_pins, .func_codes,
        .slow_scan, .retain_ref, .search_from_ref, .run_cmd, .decelerating,
        .fault_trip, .reset_key, .motor_stopped, .freq_ref, .nv_ref,
        .output_enable, .ramp_hold, .ramp_sel, .force_zero, .use_stored,
        .stored_ref, .store_strobe, .use_jog, .run_source, .freq_source,
        .run_source_lamp, .ref_lamp, .search_max, .search_ref,
        .baseblock_message, .external_fault_message,
        .overheat_warning_message, .message_input, .fault_active,
        .three_wire, .first_input_terminal, .second_input_terminal,
        .drive_running);
    always #2.5 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // new code assignment, then let the decoded outputs settle
    task automatic set_codes(input logic [35:0] c);
        @(posedge clock);
        func_codes <= c;
        wait_cyc(4);
    endtask
    task automatic complete_run;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        wait_cyc(5);
        check_val(freq_source, difd_pkg::SRC_TERMINAL);
        check_val(run_source_lamp, 1'b1);
        check_val(output_enable, 1'b0);
        @(posedge clock);
        rstn <= 1'b1;
        wait_cyc(4);
        check_val(drive_running, 1'b1);
        @(posedge clock) fault_trip <= 1'b1;
        @(posedge clock) fault_trip <= 1'b0;
        wait_cyc(3);
        check_val(fault_active, 1'b1);
        check_val(output_enable, 1'b0);
        @(posedge clock) reset_key <= 1'b1;
        wait_cyc(3);
        check_val(fault_active, 1'b1);
        @(posedge clock) run_cmd <= 1'b0;
        wait_cyc(4);
        check_val(fault_active, 1'b0);
        @(posedge clock) begin
            reset_key <= 1'b0;
            run_cmd <= 1'b1;
            press <= 6'h3F;
        end
        for (i = 0; i < 900000 && overheat_warning_message !== 1'b1; i++)
            @(posedge clock);
        if (i >= 900000) begin
            failures++;
        end
        wait_cyc(2);
        check_val(output_enable, 1'b1);
        set_codes({30'h0, difd_pkg::FN_JOG});
        check_val(use_jog, 1'b1);
        check_val(overheat_warning_message, 1'b0);
        set_codes({30'h0, difd_pkg::FN_ACC2});
        check_val(ramp_sel, difd_pkg::RAMP_SET2);
        set_codes({30'h0, difd_pkg::FN_ALT_RUN});
        check_val(run_source, difd_pkg::SRC_ALT);
        set_codes({30'h0, difd_pkg::FN_ALT_FREQ});
        check_val(freq_source, difd_pkg::SRC_ALT);
        set_codes({18'h0, difd_pkg::FN_ALT_FREQ, difd_pkg::FN_LOCAL,
                   difd_pkg::FN_ALT_RUN});
        check_val(run_source, difd_pkg::SRC_KEYPAD);
        check_val(freq_source, difd_pkg::SRC_KEYPAD);
        check_val(ref_lamp, 1'b0);
        set_codes({30'h0, difd_pkg::FN_COMM});
        check_val(run_source, difd_pkg::SRC_COMM);
        check_val(freq_source, difd_pkg::SRC_COMM);
        check_val(ref_lamp, 1'b1);
        set_codes({18'h0, difd_pkg::FN_THREE_WIRE, 6'h00, difd_pkg::FN_LOCAL});
        check_val(three_wire, 1'b1);
        check_val(first_input_terminal, 1'b1);
        check_val(second_input_terminal, 1'b1);
        check_val(run_source_lamp, 1'b1);
        set_codes({30'h0, difd_pkg::FN_SEARCH_MAX});
        check_val(search_max, 1'b1);
        set_codes({30'h0, difd_pkg::FN_SEARCH_REF});
        check_val(search_ref, 1'b1);
        set_codes({30'h0, difd_pkg::FN_HOLD});
        check_val(ramp_hold, 1'b1);
        check_val(stored_ref, 16'h1234);
        check_val(use_stored, 1'b1);
        @(posedge clock) retain_ref <= 1'b0;
        wait_cyc(3);
        check_val(force_zero, 1'b1);
        check_val(use_stored, 1'b0);
        @(posedge clock) retain_ref <= 1'b1;
        set_codes({30'h0, 6'h3F});
        check_val(ramp_hold, 1'b0);
        check_val(use_jog, 1'b0);
        set_codes({30'h0, difd_pkg::FN_BASEBLOCK});
        check_val(baseblock_message, 1'b1);
        check_val(message_input, 3'h1);
        @(posedge clock) func_codes <= 36'h0;
        wait_cyc(2);
        check_val(search_ref, 1'b1);
        wait_cyc(2);
        check_val(output_enable, 1'b1);
        @(posedge clock) decelerating <= 1'b1;
        set_codes({30'h0, difd_pkg::FN_BASEBLOCK});
        @(posedge clock) decelerating <= 1'b0;
        set_codes(36'h0);
        check_val(drive_running, 1'b0);
        @(posedge clock) run_cmd <= 1'b0;
        @(posedge clock) run_cmd <= 1'b1;
        set_codes({30'h0, difd_pkg::FN_ESTOP});
        check_val(ramp_sel, difd_pkg::RAMP_ESTOP);
        check_val(drive_running, 1'b1);
        @(posedge clock) motor_stopped <= 1'b1;
        wait_cyc(3);
        check_val(drive_running, 1'b0);
        set_codes({30'h0, difd_pkg::FN_EXT_FAULT});
        check_val(external_fault_message, 1'b1);
        check_val(message_input, 3'h1);
        set_codes({30'h0, difd_pkg::FN_FAULT_RST});
        check_val(fault_active, 1'b1);
        @(posedge clock) run_cmd <= 1'b0;
        wait_cyc(4);
        check_val(fault_active, 1'b0);
        complete_run;
    end
endmodule
